/* src/acq_trig_pkg.sv */
package acq_trig_pkg;
  localparam int        SAMPLE_W       = 16;
  localparam int        COUNT_W        = 7;
  localparam int        WADDR_W        = 7;
  localparam logic [6:0] COUNT_MIN     = 7'h01;
  localparam logic [6:0] COUNT_MAX     = 7'h64;
  localparam logic [6:0] COUNT_RST     = 7'h01;
  localparam logic [15:0] BAND_RST     = 16'h0000;
  localparam logic [15:0] LEVEL_RST    = 16'h0000;

  typedef enum logic {
    SRC_BUS      = 1'b0,
    SRC_INTERNAL = 1'b1
  } trig_source_t;

  typedef enum logic [1:0] {
    EDGE_RISING  = 2'b00,
    EDGE_FALLING = 2'b01,
    EDGE_EITHER  = 2'b10
  } edge_dir_t;

  typedef enum logic [1:0] {
    ZONE_BELOW = 2'b00,
    ZONE_INSIDE = 2'b01,
    ZONE_ABOVE = 2'b10
  } band_zone_t;

  typedef enum logic [1:0] {
    ACQ_IDLE    = 2'b00,
    ACQ_ARMED   = 2'b01,
    ACQ_CAPTURE = 2'b10
  } acq_state_t;

  localparam trig_source_t SOURCE_RST = SRC_INTERNAL;
  localparam edge_dir_t    EDGE_RST   = EDGE_EITHER;
endpackage

/* src/band_crossing.sv */
`timescale 1ns/100ps
module band_crossing (
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic                          arm,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0] sample,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0] level,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0] band_width,
  input  wire acq_trig_pkg::edge_dir_t       edge_dir,
  output logic                               hit
);
  import acq_trig_pkg::*;

  logic [SAMPLE_W:0] upper_lim;
  logic [SAMPLE_W:0] lower_lim;
  logic [SAMPLE_W:0] half_band;
  logic [SAMPLE_W:0] sample_x;
  band_zone_t        zone;
  band_zone_t        origin_q;
  band_zone_t        origin_d;
  logic              rise_hit;
  logic              fall_hit;

  // band centred on level, half width each side
  assign half_band = {2'b00, band_width[SAMPLE_W-1:1]};
  assign upper_lim = {1'b0, level} + half_band;
  assign lower_lim = ({1'b0, level} > half_band) ? ({1'b0, level} - half_band) : '0;
  assign sample_x  = {1'b0, sample};
  assign zone      = (sample_x < lower_lim) ? ZONE_BELOW :
                     (sample_x > upper_lim) ? ZONE_ABOVE : ZONE_INSIDE;

  // a crossing counts only from the far side of the band
  assign rise_hit = (origin_q == ZONE_BELOW) && (zone == ZONE_ABOVE);
  assign fall_hit = (origin_q == ZONE_ABOVE) && (zone == ZONE_BELOW);
  assign hit = arm && ((edge_dir != EDGE_FALLING && rise_hit) ||
                       (edge_dir != EDGE_RISING  && fall_hit));

  // origin tracks last side outside the band; inside keeps it
  assign origin_d = (zone == ZONE_INSIDE) ? origin_q : zone;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      origin_q <= ZONE_INSIDE;
    end else if (!arm) begin
      origin_q <= ZONE_INSIDE;
    end else begin
      origin_q <= origin_d;
    end
  end
endmodule

/* src/measurement_acquire_trigger.sv */
`timescale 1ns/100ps
// What this block does
// - while initiated with bus source, an immediate acquire command becomes a measurement trigger
// - each trigger samples voltage and current and stores both in the buffer
// - current trigger count settable 1 to 100, reset value 1
// - voltage trigger count settable 1 to 100, reset value 1
// - after each measurement wait for next valid trigger until count used up
// - band limits are level plus and minus half the band width
// - positive trigger: start below lower limit, then pass upper limit
// - negative trigger: start above upper limit, then pass lower limit
// - separate current and voltage band widths, reset to zero
// - internal triggers start only after the signal crosses the whole band
// - trigger source bus or internal level crossing, internal after reset
// - separate edge selects rising, falling or either; either after reset
// - separate current and voltage trigger levels centre the band
// - trigger commands ignored while the sequence is not initiated
module measurement_acquire_trigger (
  input  wire logic                                sys_clk,
  input  wire logic                                srst,
  input  wire logic                                initiate,
  input  wire logic                                abort,
  input  wire logic                                acquire_trigger_command,
  input  wire logic                                setting_write,
  input  wire logic [acq_trig_pkg::COUNT_W-1:0]    current_trigger_count,
  input  wire logic [acq_trig_pkg::COUNT_W-1:0]    voltage_trigger_count,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0]   current_band_width,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0]   voltage_band_width,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0]   current_trigger_level,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0]   voltage_trigger_level,
  input  wire acq_trig_pkg::trig_source_t          trigger_source,
  input  wire acq_trig_pkg::edge_dir_t             current_edge_select,
  input  wire acq_trig_pkg::edge_dir_t             voltage_edge_select,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0]   voltage_sample,
  input  wire logic [acq_trig_pkg::SAMPLE_W-1:0]   current_sample,
  output logic                                     measure_sequence_trigger,
  output logic                                     buffer_write,
  output logic [acq_trig_pkg::WADDR_W-1:0]         buffer_addr,
  output logic [acq_trig_pkg::SAMPLE_W-1:0]        buffer_voltage,
  output logic [acq_trig_pkg::SAMPLE_W-1:0]        buffer_current,
  output logic                                     waiting_for_trigger,
  output logic                                     sequence_done,
  output logic [acq_trig_pkg::COUNT_W-1:0]         triggers_taken
);
  import acq_trig_pkg::*;

  acq_state_t            state_q;
  acq_state_t            state_d;
  logic [COUNT_W-1:0]    curr_count_q;
  logic [COUNT_W-1:0]    volt_count_q;
  logic [SAMPLE_W-1:0]   curr_band_q;
  logic [SAMPLE_W-1:0]   volt_band_q;
  logic [SAMPLE_W-1:0]   curr_level_q;
  logic [SAMPLE_W-1:0]   volt_level_q;
  trig_source_t          source_q;
  edge_dir_t             curr_edge_q;
  edge_dir_t             volt_edge_q;
  logic [COUNT_W-1:0]    taken_q;
  logic [COUNT_W-1:0]    target_cnt;
  logic                  armed;
  logic                  curr_hit;
  logic                  volt_hit;
  logic                  trig_event;
  logic                  last_one;
  logic                  curr_cnt_ok;
  logic                  volt_cnt_ok;
  logic                  trig_q;
  logic                  done_q;
  logic                  wr_q;
  logic [WADDR_W-1:0]    addr_q;
  logic [SAMPLE_W-1:0]   vbuf_q;
  logic [SAMPLE_W-1:0]   ibuf_q;

  assign curr_cnt_ok = (current_trigger_count >= COUNT_MIN) && (current_trigger_count <= COUNT_MAX);
  assign volt_cnt_ok = (voltage_trigger_count >= COUNT_MIN) && (voltage_trigger_count <= COUNT_MAX);

  // settings, written on setting_write in any state (counts only when 1 to 100); held otherwise
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      curr_count_q <= COUNT_RST;
      volt_count_q <= COUNT_RST;
      curr_band_q  <= BAND_RST;
      volt_band_q  <= BAND_RST;
      curr_level_q <= LEVEL_RST;
      volt_level_q <= LEVEL_RST;
      source_q     <= SOURCE_RST;
      curr_edge_q  <= EDGE_RST;
      volt_edge_q  <= EDGE_RST;
    end else if (setting_write) begin
      if (curr_cnt_ok) begin
        curr_count_q <= current_trigger_count;
      end
      if (volt_cnt_ok) begin
        volt_count_q <= voltage_trigger_count;
      end
      curr_band_q  <= current_band_width;
      volt_band_q  <= voltage_band_width;
      curr_level_q <= current_trigger_level;
      volt_level_q <= voltage_trigger_level;
      source_q     <= trigger_source;
      curr_edge_q  <= (current_edge_select == EDGE_RISING || current_edge_select == EDGE_FALLING) ?
                      current_edge_select : EDGE_EITHER;
      volt_edge_q  <= (voltage_edge_select == EDGE_RISING || voltage_edge_select == EDGE_FALLING) ?
                      voltage_edge_select : EDGE_EITHER;
    end
  end

  // one initiation covers the larger of the two counts
  assign target_cnt = (curr_count_q > volt_count_q) ? curr_count_q : volt_count_q;
  assign armed      = (state_q == ACQ_ARMED);

  band_crossing u_curr_band (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .arm        (armed && source_q == SRC_INTERNAL),
    .sample     (current_sample),
    .level      (curr_level_q),
    .band_width (curr_band_q),
    .edge_dir   (curr_edge_q),
    .hit        (curr_hit)
  );

  band_crossing u_volt_band (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .arm        (armed && source_q == SRC_INTERNAL),
    .sample     (voltage_sample),
    .level      (volt_level_q),
    .band_width (volt_band_q),
    .edge_dir   (volt_edge_q),
    .hit        (volt_hit)
  );

  // commands outside the armed state fall through unheard
  // abort wins over a trigger arriving in the same cycle
  assign trig_event = armed && !abort && ((source_q == SRC_BUS && acquire_trigger_command) ||
                                (source_q == SRC_INTERNAL && (curr_hit || volt_hit)));
  assign last_one   = (taken_q + 7'h01 >= target_cnt);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ACQ_IDLE: begin
        if (initiate) begin
          state_d = ACQ_ARMED;
        end
      end
      ACQ_ARMED: begin
        if (trig_event) begin
          state_d = ACQ_CAPTURE;
        end
      end
      ACQ_CAPTURE: begin
        state_d = last_one ? ACQ_IDLE : ACQ_ARMED;
      end
      default: begin
        state_d = ACQ_IDLE;
      end
    endcase
    if (abort) begin
      state_d = ACQ_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ACQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      taken_q <= '0;
    end else if (state_q == ACQ_IDLE && initiate) begin
      taken_q <= '0;
    end else if (state_q == ACQ_CAPTURE) begin
      taken_q <= taken_q + 7'h01;
    end
  end

  // sample both channels on the trigger edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trig_q <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= '0;
      vbuf_q <= '0;
      ibuf_q <= '0;
      done_q <= 1'b0;
    end else begin
      trig_q <= trig_event;
      wr_q   <= trig_event;
      if (trig_event) begin
        addr_q <= taken_q;
        vbuf_q <= voltage_sample;
        ibuf_q <= current_sample;
      end
      done_q <= (state_q == ACQ_CAPTURE) && last_one && !abort;
    end
  end

  assign measure_sequence_trigger = trig_q;
  assign buffer_write             = wr_q;
  assign buffer_addr              = addr_q;
  assign buffer_voltage           = vbuf_q;
  assign buffer_current           = ibuf_q;
  assign waiting_for_trigger      = (state_q != ACQ_IDLE);
  assign sequence_done            = done_q;
  assign triggers_taken           = taken_q;
endmodule

/* tb/acq_trig_sva.sv */
`timescale 1ns/100ps
module acq_trig_sva (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        initiate,
  input wire logic        abort,
  input wire logic        acquire_trigger_command,
  input wire logic        setting_write,
  input wire acq_trig_pkg::trig_source_t trigger_source,
  input wire logic [15:0] voltage_sample,
  input wire logic [15:0] current_sample,
  input wire logic        measure_sequence_trigger,
  input wire logic        buffer_write,
  input wire logic [6:0]  buffer_addr,
  input wire logic [15:0] buffer_voltage,
  input wire logic [15:0] buffer_current,
  input wire logic        waiting_for_trigger,
  input wire logic        sequence_done,
  input wire logic [6:0]  triggers_taken
);
  import acq_trig_pkg::*;
  trig_source_t src_q;
  wire          meas = measure_sequence_trigger;
  wire          wtg = waiting_for_trigger;
  // copy of the stored source so the bus rule can be judged
  always_ff @(posedge sys_clk) begin
    if (srst) src_q <= SOURCE_RST;
    else if (setting_write) src_q <= trigger_source;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_pair; meas == buffer_write; endproperty
  a_pair: assert property (p_pair) else $error("write not paired");
  property p_data;
    meas |-> buffer_voltage == $past(voltage_sample) && buffer_current == $past(current_sample);
  endproperty
  a_data: assert property (p_data) else $error("buffer data wrong");
  property p_space; meas |=> !meas; endproperty
  a_space: assert property (p_space) else $error("triggers too close");
  property p_idle; !wtg |=> !meas; endproperty
  a_idle: assert property (p_idle) else $error("trigger while idle");
  property p_bus;
    wtg && !meas && acquire_trigger_command && src_q == SRC_BUS && !abort |=> meas;
  endproperty
  a_bus: assert property (p_bus) else $error("bus trigger lost");
  property p_addr; meas |-> buffer_addr == triggers_taken ##1 triggers_taken == buffer_addr + 7'h01; endproperty
  a_addr: assert property (p_addr) else $error("index wrong");
  property p_done; sequence_done |-> $past(meas) && !wtg; endproperty
  a_done: assert property (p_done) else $error("done wrong");
  property p_abort; abort |=> !wtg && !meas; endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_arm; $rose(wtg) |-> $past(initiate); endproperty
  a_arm: assert property (p_arm) else $error("armed without initiate");
  c_done: cover property (sequence_done);
  c_bus: cover property (meas && src_q == SRC_BUS);
  c_int: cover property (meas && src_q == SRC_INTERNAL);
endmodule

/* tb/host_model.sv */
`timescale 1ns/100ps
module host_model (
  input  wire logic                  sys_clk,
  output logic                       initiate,
  output logic                       abort,
  output logic                       acquire_trigger_command,
  output logic                       setting_write,
  output logic [6:0]                 current_trigger_count,
  output logic [6:0]                 voltage_trigger_count,
  output logic [15:0]                current_band_width,
  output logic [15:0]                voltage_band_width,
  output logic [15:0]                current_trigger_level,
  output logic [15:0]                voltage_trigger_level,
  output acq_trig_pkg::trig_source_t trigger_source,
  output acq_trig_pkg::edge_dir_t    current_edge_select,
  output acq_trig_pkg::edge_dir_t    voltage_edge_select
);
  import acq_trig_pkg::*;
  initial begin
    {initiate, abort, acquire_trigger_command, setting_write} = 4'h0;
    {current_trigger_count, voltage_trigger_count} = {COUNT_RST, COUNT_RST};
    {current_band_width, voltage_band_width} = {BAND_RST, BAND_RST};
    {current_trigger_level, voltage_trigger_level} = {LEVEL_RST, LEVEL_RST};
    trigger_source = SOURCE_RST;
    current_edge_select = EDGE_RST;
    voltage_edge_select = EDGE_RST;
  end
  // band w wide around level l on both channels
  task automatic setup(input logic [6:0] cc, vc, input trig_source_t s, input edge_dir_t e,
                       input logic [15:0] w, l);
    @(negedge sys_clk);
    current_trigger_count = cc;
    voltage_trigger_count = vc;
    {current_band_width, voltage_band_width} = {w, w};
    {current_trigger_level, voltage_trigger_level} = {l, l};
    trigger_source = s;
    current_edge_select = e;
    voltage_edge_select = e;
    setting_write = 1'b1;
    @(negedge sys_clk);
    setting_write = 1'b0;
  endtask
  // 0 initiate, 1 bus trigger, 2 abort
  task automatic pulse(input int k);
    @(negedge sys_clk);
    case (k)
      0: initiate = 1'b1;
      1: acquire_trigger_command = 1'b1;
      default: abort = 1'b1;
    endcase
    @(negedge sys_clk);
    {initiate, acquire_trigger_command, abort} = 3'h0;
  endtask
endmodule

/* tb/measurement_acquire_trigger_tb.sv */
`timescale 1ns/100ps
module measurement_acquire_trigger_tb;
  import acq_trig_pkg::*;
  logic         sys_clk, srst, initiate, abort, acquire_trigger_command, setting_write;
  logic [6:0]   current_trigger_count, voltage_trigger_count, triggers_taken, buffer_addr;
  logic [15:0]  current_band_width, voltage_band_width, current_trigger_level, voltage_trigger_level;
  logic [15:0]  voltage_sample, current_sample, buffer_voltage, buffer_current;
  trig_source_t trigger_source;
  edge_dir_t    current_edge_select, voltage_edge_select;
  logic         measure_sequence_trigger, buffer_write, waiting_for_trigger, sequence_done;
  int           err_total, cmp_count;
  measurement_acquire_trigger i_measurement_acquire_trigger (.*);
  host_model i_host_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_meas(input logic e, input logic [6:0] a, input logic [15:0] v, c);
    logic hit;
    hit = measure_sequence_trigger;
    for (int i = 0; i < 4 && hit !== 1'b1; i++) begin
      @(negedge sys_clk);
      hit = measure_sequence_trigger;
    end
    chk("trigger", {15'h0000, e}, {15'h0000, hit});
    if (e && hit !== 1'b1) finish_test();
    if (hit === 1'b1) begin
      chk("addr", {9'h000, a}, {9'h000, buffer_addr});
      chk("volt", v, buffer_voltage);
      chk("curr", c, buffer_current);
    end
  endtask
  task automatic smp(input logic [15:0] v, c, input logic e, input logic [6:0] a);
    @(negedge sys_clk);
    voltage_sample = v;
    current_sample = c;
    check_meas(e, a, v, c);
  endtask
  initial begin
    err_total = 0;
    cmp_count = 0;
    srst = 1'b1;
    voltage_sample = 16'h0100;
    current_sample = 16'h0100;
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    chk("waiting", 16'h0000, {15'h0000, waiting_for_trigger});
    i_host_model.setup(7'h03, 7'h02, SRC_BUS, EDGE_EITHER, 16'h0040, 16'h0100);
    i_host_model.pulse(1);
    check_meas(1'b0, 7'h00, 16'h0100, 16'h0100);
    i_host_model.pulse(0);
    chk("waiting", 16'h0001, {15'h0000, waiting_for_trigger});
    for (int k = 0; k < 3; k++) begin
      voltage_sample = 16'h0200 + k[15:0];
      current_sample = 16'h0300 + k[15:0];
      i_host_model.pulse(1);
      check_meas(1'b1, k[6:0], 16'h0200 + k[15:0], 16'h0300 + k[15:0]);
    end
    @(negedge sys_clk);
    chk("done", 16'h0001, {15'h0000, sequence_done});
    chk("taken", 16'h0003, {9'h000, triggers_taken});
    i_host_model.pulse(1);
    check_meas(1'b0, 7'h00, 16'h0202, 16'h0302);
    i_host_model.setup(7'h02, 7'h01, SRC_INTERNAL, EDGE_RISING, 16'h0040, 16'h0100);
    i_host_model.pulse(0);
    smp(16'h0100, 16'h00e8, 1'b0, 7'h00);
    smp(16'h0100, 16'h0130, 1'b0, 7'h00);
    smp(16'h0100, 16'h00d0, 1'b0, 7'h00);
    smp(16'h0100, 16'h0118, 1'b0, 7'h00);
    smp(16'h0100, 16'h0128, 1'b1, 7'h00);
    smp(16'h0100, 16'h00d0, 1'b0, 7'h00);
    smp(16'h0100, 16'h0128, 1'b1, 7'h01);
    i_host_model.setup(7'h01, 7'h01, SRC_INTERNAL, EDGE_FALLING, 16'h0080, 16'h0200);
    i_host_model.pulse(0);
    smp(16'h0250, 16'h0200, 1'b0, 7'h00);
    smp(16'h01e0, 16'h0200, 1'b0, 7'h00);
    smp(16'h01a0, 16'h0200, 1'b1, 7'h00);
    i_host_model.pulse(0);
    i_host_model.pulse(2);
    chk("waiting", 16'h0000, {15'h0000, waiting_for_trigger});
    smp(16'h0250, 16'h0200, 1'b0, 7'h00);
    smp(16'h01a0, 16'h0200, 1'b0, 7'h00);
    finish_test();
  end
endmodule
bind measurement_acquire_trigger acq_trig_sva i_acq_trig_sva (.*);
